/* File: bench/dac_debug_access_tb.sv */
// self-checking bench of the debug access control block
`timescale 1ns/1ps
module dac_debug_access_tb;
  logic clk = 1'b0, rst = 1'b1, fw = 1'b0, tck = 1'b0, run = 1'b1, trst_n = 1'b0;
  logic tm = 1'b1, ti = 1'b0, tdo;
  logic [35:0] o;
  logic pcv = 1'b0, mv = 1'b0, ack = 1'b0, dm, dp, tdo_oe, dp_o, dp_oe, halt, step;
  logic req, we, den, jen, kw;
  logic [15:0] pc = 16'h0, ma = 16'h0, r, a, addr;
  logic [7:0] md = 8'h0, rd = 8'h0, gp = 8'h0, wd, b;
  logic [1:0] pair;
  logic [31:0] lfsr = 32'hb9837726;
  int num_errors = 0, checks_done = 0, cyc = 0, nstep = 0, n;
  wire dp_w = dp_oe ? dp_o : dp;
  always #20 clk = ~clk;
  // the link clock only runs in bursts, still in between
  always #3 tck = run ? ~tck : 1'b0;
  dac_debug_access u_dut (.core_clk_i(clk), .reset_i(rst), .fw_dbg_enable_i(fw),
    .tck_i(tck), .tms_i(tm), .tdi_i(ti), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .tms_o(), .tms_oe_o(), .usb_dp_i(dp_w), .usb_dm_i(dm), .usb_dp_o(dp_o),
    .usb_dp_oe_o(dp_oe), .gpio_scan_i(gp), .cpu_pc_i(pc), .cpu_pc_valid_i(pcv),
    .cpu_mem_addr_i(ma), .cpu_mem_data_i(md), .cpu_mem_valid_i(mv), .cpu_halt_o(halt),
    .cpu_step_o(step), .dbg_req_o(req), .dbg_we_o(we), .dbg_addr_o(addr),
    .dbg_wdata_o(wd), .dbg_rdata_i(rd), .dbg_ack_i(ack), .on_chip_debug_en_o(den),
    .jtag_en_o(jen), .swd_pair_o(pair), .key_window_o(kw));
  dac_probe_model u_probe (.clk_i(clk), .sdat_i(dp_w), .sclk_o(dm), .sdat_o(dp));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (step === 1'b1) nstep <= nstep + 1;
    if (cyc == 30000) begin
      num_errors++;
      $display("[ERR] %0t run timed out", $time);
      end_sim();
    end
  end
  always @(posedge clk) begin
    #1;
    {gp, ma, md} = rnd();
    mv = ^lfsr;
  end
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic go(dac_pkg::dac_op_e op, logic [15:0] ad, logic [15:0] d);
    u_probe.frame(dac_pkg::dac_cmd_s'{op, ad, d}, r);
    tick(8);
  endtask
  task automatic wreq_ack(logic [7:0] v);
    n = 0;
    while (req !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    rd = v;
    ack = 1'b1;
    tick(1);
    ack = 1'b0;
  endtask
  // scan port from idle: load the instruction, then shift a 36-bit data register lsb first
  task automatic jt(logic [3:0] ir, logic [35:0] c, output logic [35:0] q);
    logic [50:0] tv, dv;
    tv = 51'h3_0000_0000_0706;
    dv = {2'b0, c, 4'h0, ir, 5'h0};
    run = 1'b1;
    for (int i = 0; i < 51; i++) begin
      @(negedge tck);
      tm = tv[i];
      ti = dv[i];
      @(posedge tck);
      if (i > 12 && i < 49) q[i-13] = tdo;
    end
    run = 1'b0;
  endtask
  initial begin
    tick(4);
    rst = 1'b0;
    // the tap saw its reset while the link clock ran; stop it before the key window
    run = 1'b0;
    u_probe.key(dac_pkg::KEY_PATTERN_RST);
    tick(3);
    chk(16'(pair), 16'h2);
    chk(16'(jen), 16'h1);
    chk(16'(den), 16'h0);
    go(dac_pkg::OP_HALT, 16'h0, 16'h0);
    chk(16'(halt), 16'h0);
    fw = 1'b1;
    tick(1);
    fw = 1'b0;
    tick(2);
    chk(16'(den), 16'h1);
    trst_n = 1'b1;
    run = 1'b1;
    tick(2);
    run = 1'b0;
    chk(16'(tdo_oe), 16'h0);
    go(dac_pkg::OP_HALT, 16'h0, 16'h0);
    chk(16'(halt), 16'h1);
    go(dac_pkg::OP_STEP, 16'h0, 16'h0);
    chk(16'(nstep), 16'h1);
    for (int i = 0; i < 8; i++) begin
      a = rnd();
      go(dac_pkg::OP_BPSET, 16'h8 | 16'(i), a);
      go(dac_pkg::OP_RUN, 16'h0, 16'h0);
      pc = a ^ 16'h1;
      pcv = 1'b1;
      tick(2);
      chk(16'(halt), 16'h0);
      pc = a;
      tick(2);
      chk(16'(halt), 16'h1);
      pcv = 1'b0;
    end
    a = rnd();
    b = lfsr[31:24];
    go(dac_pkg::OP_MRD, a, 16'h0);
    wreq_ack(b);
    chk(addr, a);
    go(dac_pkg::OP_MWR, ~a, {8'h0, ~b});
    chk(16'(r[7:0]), 16'(b));
    wreq_ack(8'h0);
    chk({we, 7'h0, wd}, {1'b1, 7'h0, ~b});
    go(dac_pkg::OP_JTDIS, 16'h0, 16'h0);
    chk(16'(jen), 16'h0);
    go(dac_pkg::OP_JTEN, 16'h0, 16'h0);
    chk(16'(jen), 16'h1);
    go(dac_pkg::OP_SWDDIS, 16'h0, 16'h0);
    chk(16'(pair), 16'h0);
    jt(dac_pkg::IR_DBGCMD, dac_pkg::dac_cmd_s'{dac_pkg::OP_SWDEN, 16'h0, 16'h0}, o);
    tick(8);
    chk(16'(pair), 16'h2);
    jt(dac_pkg::IR_IDCODE, 36'h0, o);
    chk(o[15:0], dac_pkg::IDCODE_RST[15:0]);
    chk(o[31:16], dac_pkg::IDCODE_RST[31:16]);
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    n = 0;
    while (kw === 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk(16'(n), 16'(dac_pkg::KEY_WIN_CYC));
    chk(16'(den), 16'h0);
    u_probe.key(dac_pkg::KEY_PATTERN_RST);
    tick(3);
    chk(16'(pair), 16'h0);
    end_sim();
  end
endmodule

/* File: bench/dac_probe_model.sv */
// serial debug probe model on one pin pair
`timescale 1ns/1ps
module dac_probe_model (
  input wire logic clk_i,
  input wire logic sdat_i,
  output logic sclk_o,
  output logic sdat_o
);
  initial begin
    sclk_o = 1'b0;
    sdat_o = 1'b0;
  end
  task automatic wt(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // eight core cycles a bit stays well under a third of the cpu clock
  task automatic put(logic b);
    sdat_o = b;
    wt(4);
    sclk_o = 1'b1;
    wt(4);
    sclk_o = 1'b0;
  endtask
  task automatic key(logic [15:0] k);
    for (int i = 15; i >= 0; i--) put(k[i]);
  endtask
  task automatic frame(logic [35:0] c, output logic [15:0] r);
    logic [15:0] v;
    put(1'b1);
    for (int i = 35; i >= 0; i--) put(c[i]);
    // released line shows the inverse so a stale value cannot pass
    sdat_o = ~sdat_o;
    for (int i = 15; i >= 0; i--) begin
      wt(8);
      v[i] = sdat_i;
      sclk_o = 1'b1;
      wt(4);
      sclk_o = 1'b0;
    end
    wt(8);
    r = v;
  endtask
endmodule

/* File: common/dac_pkg.sv */
// shared constants and types of the debug access control block
package dac_pkg;
  localparam int CORE_CLK_KHZ = 25000;
  localparam int KEY_WIN_NS = 8000;
  // longest time, so round down
  localparam int KEY_WIN_CYC = KEY_WIN_NS * CORE_CLK_KHZ / 1000000;
  localparam logic [7:0] KEY_WIN_LAST = 8'(KEY_WIN_CYC - 1);
  localparam int KEY_LEN = 16;
  localparam logic [15:0] KEY_PATTERN_RST = 16'h7b2d;
  // identification value is arbitrary
  localparam logic [31:0] IDCODE_RST = 32'h0a5c_3e01;
  localparam int NUM_BP = 8;
  localparam int CMD_W = 36;
  localparam int RESP_W = 16;
  localparam int BSR_W = 8;
  localparam logic [5:0] CMD_LAST = 6'(CMD_W - 1);
  localparam logic [5:0] RESP_END = 6'(RESP_W);
  localparam logic JTAG_EN_RST = 1'b1;
  localparam logic DBG_EN_RST = 1'b0;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_SCAN = 4'h2;
  localparam logic [3:0] IR_DBGCMD = 4'h8;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_RST = IR_IDCODE;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_HALT = 4'h1, OP_RUN = 4'h2, OP_STEP = 4'h3,
    OP_MRD = 4'h4, OP_MWR = 4'h5, OP_BPSET = 4'h6, OP_MBPA = 4'h7,
    OP_MBPD = 4'h8, OP_SEQ = 4'h9, OP_SWDEN = 4'ha, OP_SWDDIS = 4'hb,
    OP_JTEN = 4'hc, OP_JTDIS = 4'hd, OP_STAT = 4'he, OP_RSVD = 4'hf
  } dac_op_e;
  typedef struct packed {
    dac_op_e op;
    logic [15:0] addr;
    logic [15:0] data;
  } dac_cmd_s;
  typedef enum logic [1:0] {PAIR_NONE = 2'h0, PAIR_JTAG = 2'h1, PAIR_USB = 2'h2} dac_pair_e;
  typedef enum logic [3:0] {
    TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SELDR = 4'h2, TAP_CAPDR = 4'h3,
    TAP_SHDR = 4'h4, TAP_EX1DR = 4'h5, TAP_PADR = 4'h6, TAP_EX2DR = 4'h7,
    TAP_UPDR = 4'h8, TAP_SELIR = 4'h9, TAP_CAPIR = 4'ha, TAP_SHIR = 4'hb,
    TAP_EX1IR = 4'hc, TAP_PAIR = 4'hd, TAP_EX2IR = 4'he, TAP_UPIR = 4'hf
  } dac_tap_e;
  typedef enum logic [1:0] {SW_IDLE = 2'h0, SW_RX = 2'h1, SW_TX = 2'h2} dac_swd_e;
  typedef enum logic [0:0] {EX_IDLE = 1'b0, EX_MEM = 1'b1} dac_exec_e;
endpackage

/* File: rtl/dac_debug_access.sv */
// debug access control: key window, scan tap, serial debug engine, breakpoints
// Operation
// - on-chip debug is off after reset; only firmware may switch it on.
// - no probe path turns debug on; only the firmware enable input does.
// - boundary-scan port with clock, mode, data in/out and optional reset.
// - scan port enabled from reset; a command can release its pins.
// - serial debug sits on scan mode/clock pins or on USB data pins.
// - serial debug is active on at most one pin pair.
// - key sequence inside the post-reset window acquires serial debug on that pair.
// - scan port can enable serial debug; serial debug can be disabled.
// - window acquisition always works; serial debug on the USB pins can re-enable the scan port.
// - serial port gives debug commands but no scan chain access.
// - scan port offers bypass and a boundary chain for board test.
// - either port halts, steps and reads or writes memory and registers.
// - eight program-address comparators halt the CPU on a match when sequence mode is off.
// - one memory breakpoint on matching address and data halts the CPU.
// - halt on an ordered, non-recursive sequence of breakpoint hits.
// - debug works at full CPU speed, in reset and in low power; here reset_i clears the core-side debug logic and there is no low-power mode.
`timescale 1ns/1ps
module dac_debug_access #(
  parameter logic [15:0] KEY_PATTERN = dac_pkg::KEY_PATTERN_RST,
  parameter logic [31:0] IDCODE = dac_pkg::IDCODE_RST
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic fw_dbg_enable_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic tms_o,
  output logic tms_oe_o,
  input wire logic usb_dp_i,
  input wire logic usb_dm_i,
  output logic usb_dp_o,
  output logic usb_dp_oe_o,
  input wire logic [7:0] gpio_scan_i,
  input wire logic [15:0] cpu_pc_i,
  input wire logic cpu_pc_valid_i,
  input wire logic [15:0] cpu_mem_addr_i,
  input wire logic [7:0] cpu_mem_data_i,
  input wire logic cpu_mem_valid_i,
  output logic cpu_halt_o,
  output logic cpu_step_o,
  output logic dbg_req_o,
  output logic dbg_we_o,
  output logic [15:0] dbg_addr_o,
  output logic [7:0] dbg_wdata_o,
  input wire logic [7:0] dbg_rdata_i,
  input wire logic dbg_ack_i,
  output logic on_chip_debug_en_o,
  output logic jtag_en_o,
  output logic [1:0] swd_pair_o,
  output logic key_window_o
);
  localparam int CW = dac_pkg::CMD_W;
  localparam int RW = dac_pkg::RESP_W;

  function automatic dac_pkg::dac_tap_e tap_next(input dac_pkg::dac_tap_e s, input logic m);
    case (s)
      dac_pkg::TAP_TLR: tap_next = m ? dac_pkg::TAP_TLR : dac_pkg::TAP_RTI;
      dac_pkg::TAP_RTI: tap_next = m ? dac_pkg::TAP_SELDR : dac_pkg::TAP_RTI;
      dac_pkg::TAP_SELDR: tap_next = m ? dac_pkg::TAP_SELIR : dac_pkg::TAP_CAPDR;
      dac_pkg::TAP_CAPDR: tap_next = m ? dac_pkg::TAP_EX1DR : dac_pkg::TAP_SHDR;
      dac_pkg::TAP_SHDR: tap_next = m ? dac_pkg::TAP_EX1DR : dac_pkg::TAP_SHDR;
      dac_pkg::TAP_EX1DR: tap_next = m ? dac_pkg::TAP_UPDR : dac_pkg::TAP_PADR;
      dac_pkg::TAP_PADR: tap_next = m ? dac_pkg::TAP_EX2DR : dac_pkg::TAP_PADR;
      dac_pkg::TAP_EX2DR: tap_next = m ? dac_pkg::TAP_UPDR : dac_pkg::TAP_SHDR;
      dac_pkg::TAP_UPDR: tap_next = m ? dac_pkg::TAP_SELDR : dac_pkg::TAP_RTI;
      dac_pkg::TAP_SELIR: tap_next = m ? dac_pkg::TAP_TLR : dac_pkg::TAP_CAPIR;
      dac_pkg::TAP_CAPIR: tap_next = m ? dac_pkg::TAP_EX1IR : dac_pkg::TAP_SHIR;
      dac_pkg::TAP_SHIR: tap_next = m ? dac_pkg::TAP_EX1IR : dac_pkg::TAP_SHIR;
      dac_pkg::TAP_EX1IR: tap_next = m ? dac_pkg::TAP_UPIR : dac_pkg::TAP_PAIR;
      dac_pkg::TAP_PAIR: tap_next = m ? dac_pkg::TAP_EX2IR : dac_pkg::TAP_PAIR;
      dac_pkg::TAP_EX2IR: tap_next = m ? dac_pkg::TAP_UPIR : dac_pkg::TAP_SHIR;
      dac_pkg::TAP_UPIR: tap_next = m ? dac_pkg::TAP_SELDR : dac_pkg::TAP_RTI;
      default: tap_next = dac_pkg::TAP_TLR;
    endcase
  endfunction

  // each data register shifts in at its own top bit, out at bit 0
  function automatic logic [CW-1:0] dr_shift(input logic [CW-1:0] d, input logic b,
                                             input logic [3:0] ir);
    logic [CW-1:0] r;
    r = d >> 1;
    case (ir)
      dac_pkg::IR_IDCODE: r[31] = b;
      dac_pkg::IR_SCAN: r[dac_pkg::BSR_W-1] = b;
      dac_pkg::IR_DBGCMD: r[CW-1] = b;
      default: r[0] = b;
    endcase
    dr_shift = r;
  endfunction

  // ---------------- link domain: scan tap ----------------
  dac_pkg::dac_tap_e tap_q;
  logic [3:0] ir_q, ir_sh_q;
  logic [CW-1:0] dr_q, cmd_hold_q;
  logic req_tgl_q, ack_seen_q, jen_q, tdo_q, tdo_oe_q;
  logic [2:0] jen_s_q, ack_s_q;
  logic [RW-1:0] resp_tck_q, resp_q;
  logic ack_tgl_q, jtag_en_q;
  wire tap_rst = ~trst_n_i;
  wire ack_ev = (ack_s_q[1] == ack_s_q[2]) && (ack_s_q[2] != ack_seen_q);

  always_ff @(posedge tck_i) begin
    if (tap_rst) begin
      jen_s_q <= {3{dac_pkg::JTAG_EN_RST}};
      jen_q <= dac_pkg::JTAG_EN_RST;
      ack_s_q <= 3'h0;
      ack_seen_q <= 1'b0;
      resp_tck_q <= '0;
    end else begin
      jen_s_q <= {jen_s_q[1:0], jtag_en_q};
      ack_s_q <= {ack_s_q[1:0], ack_tgl_q};
      jen_q <= (jen_s_q[1] == jen_s_q[2]) ? jen_s_q[2] : jen_q;
      if (ack_ev) begin
        ack_seen_q <= ack_s_q[2];
        resp_tck_q <= resp_q; // held stable by the core until the next command
      end
    end
  end

  always_ff @(posedge tck_i) begin
    if (tap_rst || !jen_q) begin
      tap_q <= dac_pkg::TAP_TLR;
      ir_q <= dac_pkg::IR_RST;
      ir_sh_q <= 4'h0;
      dr_q <= '0;
      cmd_hold_q <= '0;
      req_tgl_q <= 1'b0;
    end else begin
      tap_q <= tap_next(tap_q, tms_i);
      case (tap_q)
        dac_pkg::TAP_TLR: ir_q <= dac_pkg::IR_RST;
        dac_pkg::TAP_CAPIR: ir_sh_q <= 4'h1;
        dac_pkg::TAP_SHIR: ir_sh_q <= {tdi_i, ir_sh_q[3:1]};
        dac_pkg::TAP_UPIR: ir_q <= ir_sh_q;
        dac_pkg::TAP_CAPDR: begin
          case (ir_q)
            dac_pkg::IR_IDCODE: dr_q <= CW'(IDCODE);
            dac_pkg::IR_SCAN: dr_q <= CW'(gpio_scan_i);
            dac_pkg::IR_DBGCMD: dr_q <= CW'(resp_tck_q);
            default: dr_q <= '0;
          endcase
        end
        dac_pkg::TAP_SHDR: dr_q <= dr_shift(dr_q, tdi_i, ir_q);
        dac_pkg::TAP_UPDR: begin
          if (ir_q == dac_pkg::IR_DBGCMD) begin
            cmd_hold_q <= dr_q;
            req_tgl_q <= ~req_tgl_q;
          end
        end
        default: ir_q <= ir_q;
      endcase
    end
  end

  // tdo changes on the falling edge so the probe samples it mid-bit
  always_ff @(negedge tck_i) begin
    if (tap_rst) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q <= (tap_q == dac_pkg::TAP_SHIR) ? ir_sh_q[0] : dr_q[0];
      tdo_oe_q <= (tap_q == dac_pkg::TAP_SHIR) || (tap_q == dac_pkg::TAP_SHDR);
    end
  end

  // ---------------- core domain ----------------
  logic [3:0] pin_s0_q, pin_s1_q, pin_s2_q, pin_q, pin_prev_q;
  logic [2:0] jrq_s_q;
  logic jrq_seen_q, dbg_en_q, key_win_q, halt_q, step_q;
  logic [7:0] win_cnt_q;
  logic [15:0] key_sh_q [2];
  dac_pkg::dac_pair_e pair_q;
  dac_pkg::dac_swd_e sw_st_q;
  logic [5:0] sw_cnt_q;
  logic [CW-1:0] sw_sh_q;
  logic [RW-1:0] sw_tx_q;
  logic sw_out_q, tms_oe_q, dp_oe_q;
  dac_pkg::dac_cmd_s jt_cmd_q, sw_cmd_q, cur;
  logic jt_pend_q, sw_pend_q, src_sw_q;
  dac_pkg::dac_exec_e ex_q;
  logic req_q, we_q;
  logic [15:0] addr_q, bp_addr_q [dac_pkg::NUM_BP], mbp_addr_q;
  logic [7:0] wdata_q, mbp_data_q;
  logic [dac_pkg::NUM_BP-1:0] bp_en_q, bp_hit;
  logic mbp_en_q, seq_en_q;
  logic [2:0] seq_len_q, seq_stage_q;

  // pins from the probe: three flops, a change counts once stages 2 and 3 agree
  wire [3:0] pin_raw = {usb_dm_i, usb_dp_i, tms_i, tck_i};
  wire [3:0] pin_d = (~(pin_s1_q ^ pin_s2_q) & pin_s2_q) | ((pin_s1_q ^ pin_s2_q) & pin_q);
  wire [3:0] pin_rise = pin_q & ~pin_prev_q;
  wire [3:0] pin_fall = ~pin_q & pin_prev_q;
  wire jt_ev = (jrq_s_q[1] == jrq_s_q[2]) && (jrq_s_q[2] != jrq_seen_q);
  // pair 0: clock on tck, data on tms; pair 1: clock on D-, data on D+
  wire [1:0] key_hit;
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_key
      localparam int CK = (p == 0) ? 0 : 3;
      localparam int DA = (p == 0) ? 1 : 2;
      assign key_hit[p] = key_win_q && pin_rise[CK] &&
                          ({key_sh_q[p][14:0], pin_q[DA]} == KEY_PATTERN);
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          key_sh_q[p] <= 16'h0;
        end else if (key_win_q && pin_rise[CK]) begin
          key_sh_q[p] <= {key_sh_q[p][14:0], pin_q[DA]};
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      {pin_s0_q, pin_s1_q, pin_s2_q, pin_q, pin_prev_q} <= '0;
      // keep tracking the scan toggle so a command from before reset is not replayed
      jrq_s_q <= {jrq_s_q[1:0], req_tgl_q};
      jrq_seen_q <= jrq_s_q[2];
    end else begin
      pin_s0_q <= pin_raw;
      pin_s1_q <= pin_s0_q;
      pin_s2_q <= pin_s1_q;
      pin_q <= pin_d;
      pin_prev_q <= pin_q;
      jrq_s_q <= {jrq_s_q[1:0], req_tgl_q};
      jrq_seen_q <= jt_ev ? jrq_s_q[2] : jrq_seen_q;
    end
  end

  // window timer runs from reset release whatever the configuration
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      win_cnt_q <= 8'h0;
      key_win_q <= 1'b1;
    end else if (key_win_q) begin
      win_cnt_q <= win_cnt_q + 8'h1;
      key_win_q <= (win_cnt_q != dac_pkg::KEY_WIN_LAST);
    end
  end

  // serial debug engine on the acquired pair
  wire on_usb = (pair_q == dac_pkg::PAIR_USB);
  wire sw_on = (pair_q != dac_pkg::PAIR_NONE);
  wire sw_rise = sw_on && (on_usb ? pin_rise[3] : pin_rise[0]);
  wire sw_fall = sw_on && (on_usb ? pin_fall[3] : pin_fall[0]);
  wire sw_dat = on_usb ? pin_q[2] : pin_q[1];
  wire rx_done = (sw_st_q == dac_pkg::SW_RX) && sw_rise && (sw_cnt_q == dac_pkg::CMD_LAST);
  wire tx_end = (sw_st_q == dac_pkg::SW_TX) && sw_fall && (sw_cnt_q == dac_pkg::RESP_END);

  always_ff @(posedge core_clk_i) begin
    if (reset_i || !sw_on) begin
      sw_st_q <= dac_pkg::SW_IDLE;
      sw_cnt_q <= 6'h0;
      sw_sh_q <= '0;
      sw_tx_q <= '0;
      sw_out_q <= 1'b0;
      tms_oe_q <= 1'b0;
      dp_oe_q <= 1'b0;
    end else begin
      case (sw_st_q)
        dac_pkg::SW_IDLE: if (sw_rise && sw_dat) begin
          sw_st_q <= dac_pkg::SW_RX;
          sw_cnt_q <= 6'h0;
        end
        dac_pkg::SW_RX: if (sw_rise) begin
          sw_sh_q <= {sw_sh_q[CW-2:0], sw_dat};
          sw_cnt_q <= rx_done ? 6'h0 : sw_cnt_q + 6'h1;
          if (rx_done) begin
            sw_st_q <= dac_pkg::SW_TX;
            sw_tx_q <= resp_q; // answers with the last finished result
          end
        end
        dac_pkg::SW_TX: if (sw_fall) begin
          sw_out_q <= sw_tx_q[RW-1];
          sw_tx_q <= {sw_tx_q[RW-2:0], 1'b0};
          sw_cnt_q <= sw_cnt_q + 6'h1;
          tms_oe_q <= !tx_end && !on_usb;
          dp_oe_q <= !tx_end && on_usb;
          if (tx_end) begin
            sw_st_q <= dac_pkg::SW_IDLE;
          end
        end
        default: sw_st_q <= dac_pkg::SW_IDLE;
      endcase
    end
  end

  // command executor; the scan port wins when both wait
  wire take = (ex_q == dac_pkg::EX_IDLE) && (jt_pend_q || sw_pend_q);
  wire take_sw = take && !jt_pend_q;
  assign cur = take_sw ? sw_cmd_q : jt_cmd_q;
  wire dbg_ok = take && dbg_en_q;
  wire ex_halt = dbg_ok && (cur.op == dac_pkg::OP_HALT);
  wire ex_run = dbg_ok && (cur.op == dac_pkg::OP_RUN);
  wire ex_step = dbg_ok && (cur.op == dac_pkg::OP_STEP);
  wire ex_mem = dbg_ok && ((cur.op == dac_pkg::OP_MRD) || (cur.op == dac_pkg::OP_MWR));
  wire ex_bp = dbg_ok && (cur.op == dac_pkg::OP_BPSET);
  wire ex_swd_en = take && !take_sw && (cur.op == dac_pkg::OP_SWDEN);
  wire ex_swd_dis = take && (cur.op == dac_pkg::OP_SWDDIS);
  wire ex_jt_en = take_sw && (cur.op == dac_pkg::OP_JTEN);
  wire ex_jt_dis = take && (cur.op == dac_pkg::OP_JTDIS);
  wire mem_done = (ex_q == dac_pkg::EX_MEM) && dbg_ack_i;
  wire fin = (take && !ex_mem) || mem_done;
  wire fin_jt = fin && (mem_done ? !src_sw_q : !take_sw);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      jt_pend_q <= 1'b0;
      sw_pend_q <= 1'b0;
      jt_cmd_q <= '0;
      sw_cmd_q <= '0;
    end else begin
      // a new arrival wins over the clear of its pending flag
      jt_pend_q <= jt_ev || (jt_pend_q && !(take && !take_sw));
      sw_pend_q <= rx_done || (sw_pend_q && !take_sw);
      if (jt_ev) jt_cmd_q <= cmd_hold_q;
      if (rx_done) sw_cmd_q <= {sw_sh_q[CW-2:0], sw_dat};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ex_q <= dac_pkg::EX_IDLE;
      {req_q, we_q, src_sw_q, ack_tgl_q} <= 4'h0;
      addr_q <= 16'h0;
      wdata_q <= 8'h0;
      resp_q <= '0;
    end else begin
      ack_tgl_q <= ack_tgl_q ^ fin_jt;
      if (ex_mem) begin
        ex_q <= dac_pkg::EX_MEM;
        req_q <= 1'b1;
        we_q <= (cur.op == dac_pkg::OP_MWR);
        addr_q <= cur.addr;
        wdata_q <= cur.data[7:0];
        src_sw_q <= take_sw;
      end else if (mem_done) begin
        ex_q <= dac_pkg::EX_IDLE;
        req_q <= 1'b0;
        resp_q <= we_q ? resp_q : {8'h0, dbg_rdata_i};
      end else if (take && cur.op == dac_pkg::OP_STAT) begin
        resp_q <= {dbg_en_q, jtag_en_q, pair_q, halt_q, seq_stage_q, 8'h0};
      end
    end
  end

  // port ownership: firmware enable, window acquisition, port commands
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dbg_en_q <= dac_pkg::DBG_EN_RST;
      jtag_en_q <= dac_pkg::JTAG_EN_RST;
      pair_q <= dac_pkg::PAIR_NONE;
    end else begin
      dbg_en_q <= dbg_en_q || fw_dbg_enable_i;
      if (key_hit[0]) begin
        pair_q <= dac_pkg::PAIR_JTAG;
        jtag_en_q <= 1'b0;
      end else if (key_hit[1]) begin
        pair_q <= dac_pkg::PAIR_USB;
      end else begin
        if (ex_swd_dis) pair_q <= dac_pkg::PAIR_NONE;
        else if (ex_swd_en && pair_q == dac_pkg::PAIR_NONE) pair_q <= dac_pkg::PAIR_USB;
        if (ex_jt_dis) jtag_en_q <= 1'b0;
        else if (ex_jt_en && pair_q != dac_pkg::PAIR_JTAG) jtag_en_q <= 1'b1;
      end
    end
  end

  // breakpoints
  genvar i;
  generate
    for (i = 0; i < dac_pkg::NUM_BP; i++) begin : g_bp
      assign bp_hit[i] = bp_en_q[i] && cpu_pc_valid_i && (cpu_pc_i == bp_addr_q[i]);
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          bp_addr_q[i] <= 16'h0;
          bp_en_q[i] <= 1'b0;
        end else if (ex_bp && cur.addr[2:0] == 3'(i)) begin
          bp_addr_q[i] <= cur.data;
          bp_en_q[i] <= cur.addr[3];
        end
      end
    end
  endgenerate

  wire mbp_hit = mbp_en_q && cpu_mem_valid_i && (cpu_mem_addr_i == mbp_addr_q) &&
                 (cpu_mem_data_i == mbp_data_q);
  wire seq_hit = seq_en_q && bp_hit[seq_stage_q];
  wire seq_done = seq_hit && (seq_stage_q == seq_len_q);
  wire bp_halt = dbg_en_q && ((!seq_en_q && |bp_hit) || seq_done || mbp_hit);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      {halt_q, step_q, mbp_en_q, seq_en_q} <= 4'h0;
      mbp_addr_q <= 16'h0;
      mbp_data_q <= 8'h0;
      seq_len_q <= 3'h0;
      seq_stage_q <= 3'h0;
    end else begin
      halt_q <= bp_halt || ex_halt || (halt_q && !ex_run);
      step_q <= ex_step && halt_q;
      if (dbg_ok && cur.op == dac_pkg::OP_MBPA) mbp_addr_q <= cur.data;
      if (dbg_ok && cur.op == dac_pkg::OP_MBPD) {mbp_en_q, mbp_data_q} <= cur.data[8:0];
      if (dbg_ok && cur.op == dac_pkg::OP_SEQ) begin
        {seq_en_q, seq_len_q} <= cur.data[3:0];
        seq_stage_q <= 3'h0;
      end else if (seq_hit) begin
        seq_stage_q <= seq_done ? 3'h0 : seq_stage_q + 3'h1;
      end
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;
  assign tms_o = sw_out_q;
  assign tms_oe_o = tms_oe_q;
  assign usb_dp_o = sw_out_q;
  assign usb_dp_oe_o = dp_oe_q;
  assign cpu_halt_o = halt_q;
  assign cpu_step_o = step_q;
  assign dbg_req_o = req_q;
  assign dbg_we_o = we_q;
  assign dbg_addr_o = addr_q;
  assign dbg_wdata_o = wdata_q;
  assign on_chip_debug_en_o = dbg_en_q;
  assign jtag_en_o = jtag_en_q;
  assign swd_pair_o = pair_q;
  assign key_window_o = key_win_q;

  // checks
  win_len_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(key_win_q) |-> $past(win_cnt_q) == dac_pkg::KEY_WIN_LAST)
    else $error("key window closed at the wrong count");
  acq_window_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ($past(pair_q) == dac_pkg::PAIR_NONE && pair_q != dac_pkg::PAIR_NONE) |->
    ($past(key_win_q) || $past(ex_swd_en)))
    else $error("serial debug acquired outside the key window");
  one_pair_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !(tms_oe_q && dp_oe_q) && pair_q != 2'h3)
    else $error("serial debug active on two pairs");
  dbg_off_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !dbg_en_q |-> !halt_q && !req_q && !step_q)
    else $error("debug action while on-chip debug is off");
  dbg_sticky_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !dbg_en_q && !fw_dbg_enable_i |=> !dbg_en_q)
    else $error("debug enabled without firmware");
  reset_state_a: assert property (@(posedge core_clk_i)
    reset_i |=> jtag_en_q && !dbg_en_q && key_win_q && pair_q == dac_pkg::PAIR_NONE)
    else $error("wrong port state after reset");
  pc_halt_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (dbg_en_q && !seq_en_q && |bp_hit) |=> halt_q)
    else $error("program breakpoint did not halt");
  mem_halt_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (dbg_en_q && mbp_hit) |=> halt_q [*1])
    else $error("memory breakpoint did not halt");
  seq_halt_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (dbg_en_q && seq_en_q && !(|bp_hit) && !mbp_hit && !halt_q && !ex_halt) |=> !halt_q)
    else $error("sequence mode halted without completion");
  sequence rx_end_s;
    rx_done ##1 (sw_st_q == dac_pkg::SW_TX);
  endsequence
  swd_frame_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rx_done |-> rx_end_s ##0 sw_pend_q)
    else $error("serial frame not queued for execution");
  tap_gate_a: assert property (@(posedge tck_i) disable iff (tap_rst)
    !jen_q |=> tap_q == dac_pkg::TAP_TLR)
    else $error("tap left reset while scan port disabled");
endmodule
